// *** core/pmc_power_mode_controller.sv ***
/*
  Power-mode controller: APB registers, mode sequencer, clock and bias controls.
  Assumes wake and interrupt inputs are pins or other-domain signals, synchronised here;
  the clock gate enables drive gating cells outside this block.
*/
// Our own choices: the APB register port and the register offsets.
module pmc_power_mode_controller #(
  parameter int NumPeriph = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event inputs
  input wire logic anyIrq,
  input wire logic [pmc_pkg::NumWake-1:0] wakeSrc,
  // Clock and power controls
  output logic coreClkEn,
  output logic [NumPeriph-1:0] periphClkEn,
  output logic fastOscAEn,
  output logic fastOscBEn,
  output logic [1:0] coreClockSel,
  output logic [2:0] coreClockDiv,
  output logic slowTimerClkEn,
  output logic regLowBias,
  output logic internalPowerOff,
  output logic reg5vKeep,
  output logic pinRetain,
  output logic irq
);

  // Divide-by-power-of-two: ratio for a 3-bit code
  function automatic logic [7:0] divRatio(input logic [2:0] code);
    divRatio = 8'h01 << code;
  endfunction

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction

  logic [1:0] irqSync1, irqSync2;
  logic [pmc_pkg::NumWake-1:0] wakeSync1, wakeSync2, wakeDly;
  logic irqSeen;
  logic [pmc_pkg::NumWake-1:0] wakeRise;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqSync1 <= 2'h0;
      irqSync2 <= 2'h0;
      wakeSync1 <= '0;
      wakeSync2 <= '0;
      wakeDly <= '0;
    end
    else
    begin
      irqSync1 <= {1'b0, anyIrq};
      irqSync2 <= irqSync1;
      wakeSync1 <= wakeSrc;
      wakeSync2 <= wakeSync1;
      wakeDly <= wakeSync2;
    end
  end

  assign irqSeen = irqSync2[0];
  // Edge detect so a held level does not re-wake right after re-entry
  assign wakeRise = wakeSync2 & ~wakeDly;

  // Registers
  pmc_pkg::pmc_mode_t mode_reg, mode_next;
  logic [1:0] pctlA_reg, pctlA_next;
  logic [1:0] pctlB_reg, pctlB_next;
  logic [1:0] regCtl_reg, regCtl_next;
  logic [1:0] clkSrc_reg, clkSrc_next;
  logic [2:0] clkDiv_reg, clkDiv_next;
  logic [7:0] periphEn_reg, periphEn_next;
  logic [1:0] irqStat_reg, irqStat_next;
  logic [1:0] irqMask_reg, irqMask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [15:0] outs_reg, outs_next;

  logic setup, wr, hit;
  logic [1:0] evt;
  logic wakeNow;

  assign setup = psel && !penable;
  assign wr = setup && pwrite;

  always_comb
  begin
    mode_next = mode_reg;
    pctlA_next = pctlA_reg;
    pctlB_next = pctlB_reg;
    regCtl_next = regCtl_reg;
    clkSrc_next = clkSrc_reg;
    clkDiv_next = clkDiv_reg;
    periphEn_next = periphEn_reg;
    irqMask_next = irqMask_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    evt = 2'h0;
    hit = 1'b1;
    wakeNow = 1'b0;

    // Register access, answered one cycle after setup
    if (setup)
    begin
      pready_next = 1'b1;
      prdata_next = 32'h00000000;
      unique case (paddr)
        pmc_pkg::PowerCtlAOffs: prdata_next = {30'h0, pctlA_reg};
        pmc_pkg::PowerCtlBOffs: prdata_next = {30'h0, pctlB_reg};
        pmc_pkg::RegulatorCtlOffs: prdata_next = {30'h0, regCtl_reg};
        pmc_pkg::ClockCtlOffs: prdata_next = {25'h0, clkDiv_reg, 2'h0, clkSrc_reg};
        pmc_pkg::PeriphEnOffs: prdata_next = zext8(periphEn_reg);
        pmc_pkg::StatusOffs: prdata_next = {21'h0, divRatio(clkDiv_reg), mode_reg};
        pmc_pkg::IrqStatusOffs: prdata_next = {30'h0, irqStat_reg};
        pmc_pkg::IrqMaskOffs: prdata_next = {30'h0, irqMask_reg};
        default: hit = 1'b0;
      endcase
      pslverr_next = !hit;
      if (!hit)
        prdata_next = 32'h00000000;
    end

    // Writes only while normal (IrqStatus clear below is taken in any mode): core is halted otherwise
    if (wr && mode_reg == pmc_pkg::ModeNormal)
    begin
      unique case (paddr)
        pmc_pkg::PowerCtlAOffs:
        begin
          pctlA_next[pmc_pkg::IdleBit] = pwdata[pmc_pkg::IdleBit];
          // Stop honoured only with shutdown flag armed beforehand
          if (pwdata[pmc_pkg::StopBit] && !regCtl_reg[pmc_pkg::ShutdownCfgBit])
            evt[pmc_pkg::IrqBadStop] = 1'b1;
          else
            pctlA_next[pmc_pkg::StopBit] = pwdata[pmc_pkg::StopBit];
        end
        pmc_pkg::PowerCtlBOffs: pctlB_next = pwdata[1:0];
        pmc_pkg::RegulatorCtlOffs: regCtl_next = pwdata[1:0];
        pmc_pkg::ClockCtlOffs:
        begin
          clkSrc_next = pwdata[pmc_pkg::ClkSrcLsb +: 2];
          clkDiv_next = pwdata[pmc_pkg::ClkDivLsb +: 3];
        end
        pmc_pkg::PeriphEnOffs: periphEn_next = pwdata[7:0];
        pmc_pkg::IrqMaskOffs: irqMask_next = pwdata[1:0];
        default: hit = hit;
      endcase
    end

    // Mode sequencer; priority stop > snooze > suspend > idle
    unique case (mode_reg)
      pmc_pkg::ModeNormal:
      begin
        if (pctlA_reg[pmc_pkg::StopBit])
          mode_next = pmc_pkg::ModeShutdown;
        else if (pctlB_reg[pmc_pkg::SnoozeBit])
          mode_next = pmc_pkg::ModeSnooze;
        else if (pctlB_reg[pmc_pkg::SuspendBit])
          mode_next = pmc_pkg::ModeSuspend;
        else if (pctlA_reg[pmc_pkg::IdleBit])
          mode_next = pmc_pkg::ModeIdle;
      end
      pmc_pkg::ModeIdle: wakeNow = irqSeen;
      pmc_pkg::ModeSuspend, pmc_pkg::ModeSnooze: wakeNow = |wakeRise;
      pmc_pkg::ModeShutdown: wakeNow = 1'b0;
    endcase

    if (wakeNow)
    begin
      mode_next = pmc_pkg::ModeNormal;
      pctlA_next = 2'h0;
      pctlB_next = 2'h0;
      evt[pmc_pkg::IrqWoke] = 1'b1;
    end

    // Control outputs, registered
    outs_next = 16'h0000;
    outs_next[0] = mode_reg == pmc_pkg::ModeNormal;
    outs_next[1] = mode_reg == pmc_pkg::ModeNormal || mode_reg == pmc_pkg::ModeIdle;
    outs_next[2] = outs_next[1] || mode_reg == pmc_pkg::ModeNormal;
    outs_next[3] = mode_reg == pmc_pkg::ModeSnooze;
    outs_next[4] = mode_reg == pmc_pkg::ModeShutdown;
    outs_next[5] = outs_next[4] && regCtl_reg[pmc_pkg::Reg5vEnBit];
    outs_next[6] = mode_reg == pmc_pkg::ModeSuspend || mode_reg == pmc_pkg::ModeSnooze;
  end

  // Set wins over write-one clear
  always_comb
  begin
    irqStat_next = irqStat_reg;
    if (wr && paddr == pmc_pkg::IrqStatusOffs)
      irqStat_next = irqStat_reg & ~pwdata[1:0];
    irqStat_next = irqStat_next | evt;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= pmc_pkg::ModeNormal;
      pctlA_reg <= 2'h0;
      pctlB_reg <= 2'h0;
      regCtl_reg <= 2'h0;
      clkSrc_reg <= pmc_pkg::SrcFastOscA;
      clkDiv_reg <= pmc_pkg::ClkDivReset;
      periphEn_reg <= pmc_pkg::PeriphEnReset;
      irqStat_reg <= 2'h0;
      irqMask_reg <= 2'h0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      outs_reg <= 16'h0007;
    end
    else
    begin
      mode_reg <= mode_next;
      pctlA_reg <= pctlA_next;
      pctlB_reg <= pctlB_next;
      regCtl_reg <= regCtl_next;
      clkSrc_reg <= clkSrc_next;
      clkDiv_reg <= clkDiv_next;
      periphEn_reg <= periphEn_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      outs_reg <= outs_next;
    end
  end

  logic irq_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(irqStat_next & irqMask_next);
  end

  logic [NumPeriph-1:0] periphGate_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      periphGate_reg <= {NumPeriph{1'b1}};
    else
      periphGate_reg <= {NumPeriph{outs_next[1]}} & NumPeriph'(periphEn_next);
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign coreClkEn = outs_reg[0];
  assign periphClkEn = periphGate_reg;
  assign fastOscAEn = outs_reg[1];
  assign fastOscBEn = outs_reg[2];
  assign regLowBias = outs_reg[3];
  assign internalPowerOff = outs_reg[4];
  assign reg5vKeep = outs_reg[5];
  assign pinRetain = outs_reg[4];
  assign slowTimerClkEn = outs_reg[6];
  assign coreClockSel = clkSrc_reg;
  assign coreClockDiv = clkDiv_reg;
  assign irq = irq_reg;

  // Assertions
  a_idle_core_off: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == pmc_pkg::ModeIdle |=> !coreClkEn && fastOscAEn)
    else $error("idle clocks wrong");
  a_idle_irq_wake: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == pmc_pkg::ModeIdle && irqSeen |=> mode_reg == pmc_pkg::ModeNormal)
    else $error("idle did not wake");
  a_sleep_clocks_off: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg == pmc_pkg::ModeSuspend || mode_reg == pmc_pkg::ModeSnooze) |=>
    !fastOscAEn && !fastOscBEn && periphClkEn == '0)
    else $error("sleep clocks running");
  a_suspend_bias: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == pmc_pkg::ModeSuspend |=> !regLowBias)
    else $error("suspend bias low");
  a_snooze_bias: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == pmc_pkg::ModeSnooze |=> regLowBias && slowTimerClkEn)
    else $error("snooze bias wrong");
  a_stop_needs_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == pmc_pkg::ModeNormal && $rose(pctlA_reg[pmc_pkg::StopBit]) |->
    $past(regCtl_reg[pmc_pkg::ShutdownCfgBit]))
    else $error("stop without config");
  a_shutdown_sticks: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == pmc_pkg::ModeShutdown |=> mode_reg == pmc_pkg::ModeShutdown)
    else $error("left shutdown");
  a_wake_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_reg == pmc_pkg::ModeSuspend || mode_reg == pmc_pkg::ModeSnooze) && |wakeRise |=>
    mode_reg == pmc_pkg::ModeNormal && pctlB_reg == 2'h0)
    else $error("wake missed");
  a_shutdown_pins: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == pmc_pkg::ModeShutdown |=> internalPowerOff && pinRetain)
    else $error("shutdown outputs");
  a_div_range: assert property (@(posedge clk) disable iff (!rst_n)
    wr && mode_reg == pmc_pkg::ModeNormal && paddr == pmc_pkg::ClockCtlOffs |=>
    coreClockDiv == $past(pwdata[pmc_pkg::ClkDivLsb +: 3]))
    else $error("divider setting not taken");
  c_idle: cover property (@(posedge clk) mode_reg == pmc_pkg::ModeIdle ##1 mode_reg == pmc_pkg::ModeNormal);
  c_suspend: cover property (@(posedge clk) mode_reg == pmc_pkg::ModeSuspend);
  c_snooze: cover property (@(posedge clk) mode_reg == pmc_pkg::ModeSnooze);
  c_shutdown: cover property (@(posedge clk) mode_reg == pmc_pkg::ModeShutdown);

endmodule // pmc_power_mode_controller

// *** shared/pmc_pkg.sv ***
/*
  Constants, register map and mode enumeration of the power-mode controller.
  Assumes a 32-bit APB slave at 125 MHz with word-aligned registers.
*/
// Behaviour
// - Idle halts core, peripherals keep clocks
// - Idle bit enters idle; any interrupt wakes
// - Suspend/snooze stop core, peripherals, fast oscillators
// - Suspend keeps regulators in normal bias
// - Software selects fast_osc_a before snooze
// - Snooze puts regulators in low bias
// - Timers 3/4 may run on slow_osc/8
// - Six wake sources end suspend or snooze
// - Shutdown cuts internal power, keeps 5V, pins
// - Only reset leaves shutdown
// - Reset clock is fast_osc_a divided by 8
// - Divider offers 1 to 128 in powers of two
// - Unused digital peripherals are clock gated
package pmc_pkg;
  localparam logic [11:0] PowerCtlAOffs = 12'h000;
  localparam logic [11:0] PowerCtlBOffs = 12'h004;
  localparam logic [11:0] RegulatorCtlOffs = 12'h008;
  localparam logic [11:0] ClockCtlOffs = 12'h00c;
  localparam logic [11:0] PeriphEnOffs = 12'h010;
  localparam logic [11:0] StatusOffs = 12'h014;
  localparam logic [11:0] IrqStatusOffs = 12'h018;
  localparam logic [11:0] IrqMaskOffs = 12'h01c;
  // power_ctl_a fields
  localparam int IdleBit = 0;
  localparam int StopBit = 1;
  // power_ctl_b fields
  localparam int SuspendBit = 0;
  localparam int SnoozeBit = 1;
  // regulator_control fields
  localparam int ShutdownCfgBit = 0;
  localparam int Reg5vEnBit = 1;
  // clock control fields
  localparam int ClkSrcLsb = 0;
  localparam int ClkDivLsb = 4;
  localparam logic [1:0] SrcFastOscA = 2'h0;
  localparam logic [1:0] SrcFastOscB = 2'h1;
  localparam logic [1:0] SrcSlowOsc = 2'h2;
  localparam logic [1:0] SrcExtClk = 2'h3;
  localparam logic [2:0] ClkDivReset = 3'h3;
  localparam logic [7:0] PeriphEnReset = 8'hff;
  localparam int NumWake = 6;
  localparam int SlowDivide = 8;
  localparam int WakeUsb = 0;
  localparam int WakeTimer4 = 1;
  localparam int WakeSpi = 2;
  localparam int WakeI2c = 3;
  localparam int WakePortMatch = 4;
  localparam int WakeCmp0 = 5;
  // Interrupt status: bit0 woke, bit1 illegal shutdown entry attempt
  localparam int IrqWoke = 0;
  localparam int IrqBadStop = 1;
  typedef enum logic [2:0] {ModeNormal, ModeIdle, ModeSuspend, ModeSnooze, ModeShutdown}
    pmc_mode_t;
endpackage

// *** verification/tb_power_mode_controller.sv ***
/*
  Self-checking bench for the power-mode controller: APB master tasks and one task per scenario.
  Assumes the one-cycle APB answer, register map and mode timing of the controller's hand-over.
*/
module tb_power_mode_controller;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, anyIrq, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [pmc_pkg::NumWake-1:0] wakeSrc;
  logic coreClkEn, fastOscAEn, fastOscBEn, slowTimerClkEn, regLowBias;
  logic internalPowerOff, reg5vKeep, pinRetain;
  logic [7:0] periphClkEn;
  logic [1:0] coreClockSel;
  logic [2:0] coreClockDiv;
  int failures = 0;
  int nTests = 0;
  int cycles = 0;

  pmc_power_mode_controller #(.NumPeriph(8)) pmc_power_mode_controller_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .anyIrq(anyIrq), .wakeSrc(wakeSrc), .coreClkEn(coreClkEn), .periphClkEn(periphClkEn),
    .fastOscAEn(fastOscAEn), .fastOscBEn(fastOscBEn), .coreClockSel(coreClockSel),
    .coreClockDiv(coreClockDiv), .slowTimerClkEn(slowTimerClkEn), .regLowBias(regLowBias),
    .internalPowerOff(internalPowerOff), .reg5vKeep(reg5vKeep), .pinRetain(pinRetain),
    .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the scenarios need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    nTests = nTests + 1;
    if (act !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  // Request held until the rising edge that samples pready high; data taken there
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int guard;
    guard = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && guard < 50)
    begin
      @(posedge clk);
      guard++;
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    logic [31:0] r;
    logic e;
    apb(1'b1, addr, data, r, e);
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
    logic [31:0] r;
    logic e;
    apb(1'b0, addr, 32'h0, r, e);
    chk(exp, r);
    chk({31'h0, expErr}, {31'h0, e});
  endtask

  // Order: powerOff, pinRetain, 5V keep, low bias, slow timers, oscB, oscA, core
  task automatic chkPwr(input logic [7:0] exp, input logic [7:0] expPeriph);
    repeat (3) @(posedge clk);
    chk({24'h0, exp}, {24'h0, internalPowerOff, pinRetain, reg5vKeep, regLowBias,
        slowTimerClkEn, fastOscBEn, fastOscAEn, coreClkEn});
    chk({24'h0, expPeriph}, {24'h0, periphClkEn});
  endtask

  task automatic testReset();
    chkPwr(8'h07, 8'hff);
    chk({27'h0, pmc_pkg::SrcFastOscA, 3'h3}, {27'h0, coreClockSel, coreClockDiv});
    rd(pmc_pkg::ClockCtlOffs, 32'h30, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
  endtask

  task automatic testDivider();
    for (int i = 7; i >= 0; i--)
    begin
      wr(pmc_pkg::ClockCtlOffs, (32'(i) << pmc_pkg::ClkDivLsb) | 32'(i % 4));
      repeat (2) @(posedge clk);
      chk({27'h0, 2'(i % 4), 3'(i)}, {27'h0, coreClockSel, coreClockDiv});
      rd(pmc_pkg::StatusOffs, (32'h1 << i) << 3, 1'b0);
    end
    wr(pmc_pkg::PeriphEnOffs, 32'h0f);
    chkPwr(8'h07, 8'h0f);
    wr(pmc_pkg::PeriphEnOffs, 32'hff);
  endtask

  task automatic testIdle();
    wr(pmc_pkg::PowerCtlAOffs, 32'h1);
    chkPwr(8'h06, 8'hff);
    anyIrq <= 1'b1;
    repeat (5) @(posedge clk);
    chkPwr(8'h07, 8'hff);
    anyIrq <= 1'b0;
    rd(pmc_pkg::PowerCtlAOffs, 32'h0, 1'b0);
  endtask

  // Alternate suspend and snooze while walking every wake source
  task automatic testLowPower();
    wr(pmc_pkg::ClockCtlOffs, 32'(pmc_pkg::SrcFastOscA));
    repeat (2) @(posedge clk);
    chk(32'(pmc_pkg::SrcFastOscA), {30'h0, coreClockSel});
    for (int i = 0; i < pmc_pkg::NumWake; i++)
    begin
      wr(pmc_pkg::PowerCtlBOffs, (i % 2) ? 32'h2 : 32'h1);
      chkPwr((i % 2) ? 8'h18 : 8'h08, 8'h00);
      wakeSrc <= 6'h01 << i;
      repeat (6) @(posedge clk);
      chkPwr(8'h07, 8'hff);
      wakeSrc <= '0;
      rd(pmc_pkg::PowerCtlBOffs, 32'h0, 1'b0);
    end
  endtask

  task automatic testIrq();
    rd(pmc_pkg::IrqStatusOffs, 32'h1, 1'b0);
    chk(32'h0, {31'h0, irq});
    wr(pmc_pkg::IrqMaskOffs, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'h1, {31'h0, irq});
    wr(pmc_pkg::IrqStatusOffs, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'h0, {31'h0, irq});
    rd(pmc_pkg::IrqStatusOffs, 32'h0, 1'b0);
  endtask

  task automatic testShutdown();
    wr(pmc_pkg::PowerCtlAOffs, 32'h2);
    chkPwr(8'h07, 8'hff);
    rd(pmc_pkg::IrqStatusOffs, 32'h2, 1'b0);
    wr(pmc_pkg::RegulatorCtlOffs, 32'h3);
    wr(pmc_pkg::PowerCtlAOffs, 32'h2);
    chkPwr(8'he0, 8'h00);
    wakeSrc <= '1;
    anyIrq <= 1'b1;
    repeat (10) @(posedge clk);
    chkPwr(8'he0, 8'h00);
    wakeSrc <= '0;
    anyIrq <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chkPwr(8'h07, 8'hff);
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    anyIrq = 1'b0;
    wakeSrc = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    testReset();
    testDivider();
    testIdle();
    testLowPower();
    testIrq();
    testShutdown();
    tally_and_finish();
  end
endmodule // tb_power_mode_controller
